// file: logic/rpb_top.sv
// Relative offset, moving-average filter, mx+b math, reading buffer and statistics.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "rpb_defines.svh"
module rpb_top (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Readings from the measurement front end.
	input  wire logic        inValid,
	input  wire logic [31:0] inV,
	input  wire logic [31:0] inI,
	// Register port.
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic [31:0]      regRdata,
	// Processed readings.
	output logic             outValid,
	output logic [31:0]      outV,
	output logic [31:0]      outI
);
	import rpb_pkg::*;

	// ------------------------------------------------------------------------
	// State, memories and engine links.
	// ------------------------------------------------------------------------
	rpb_state_type st;
	rpb_state_type next_st;
	logic [31:0]   memV   [0:`RPB_BUF_DEPTH-1];
	logic [31:0]   memI   [0:`RPB_BUF_DEPTH-1];
	logic [31:0]   memTs  [0:`RPB_BUF_DEPTH-1];
	logic [31:0]   memNum [0:`RPB_BUF_DEPTH-1];
	logic          memWe;
	logic [11:0]   memAddr;
	logic [1:0][31:0] memData;
	logic [31:0]   memNumData;
	logic [1:0]    histWe;
	logic [1:0][6:0]  histAddr;
	logic [1:0][31:0] histData;
	logic [1:0][31:0] histRd;
	logic          sqDone;
	logic [31:0]   sqRoot;

	// Square root for the standard deviation.
	rpb_isqrt u_isqrt (
		.clk      (clk),
		.rst_n    (rst_n),
		.start    (st.sqStart),
		.radicand (st.sqVal),
		.done     (sqDone),
		.root     (sqRoot)
	);

	// ------------------------------------------------------------------------
	// Next-state logic.
	// ------------------------------------------------------------------------
	always_comb begin
		logic signed [31:0] x, avgOld, filt, mth, sv, sMin, sMax, mean;
		logic signed [32:0] diff;
		logic signed [63:0] prod;
		logic signed [43:0] sSum;
		logic [75:0]        sSq, sqMean, meanSq;
		logic [39:0]        sum;
		logic [6:0]         cnt;
		logic               doClear;
		logic [31:0]        ctrlWord;
		x = '0; avgOld = '0; filt = '0; mth = '0; sv = '0; sMin = '0; sMax = '0; mean = '0;
		diff = '0; prod = '0; sSum = '0; sSq = '0; sqMean = '0; meanSq = '0; sum = '0; cnt = '0;
		doClear = 1'b0;
		ctrlWord = 32'h00000000;
		next_st = st;
		next_st.tstamp = st.tstamp + 32'h00000001;
		next_st.outValid = 1'b0;
		next_st.sqStart = 1'b0;
		memWe = 1'b0;
		memAddr = st.wp;
		memData = '0;
		memNumData = 32'h00000000;
		histWe = 2'b00;
		histAddr = '0;
		histData = '0;

		// Statistics rescan over the whole buffer; results are published together when the root is ready.
		if (st.scanning) begin
			sv = $signed(st.statCur ? memI[st.scanIdx] : memV[st.scanIdx]);
			sMin = (sv < st.accMin) ? sv : st.accMin;
			sMax = (sv > st.accMax) ? sv : st.accMax;
			sSum = st.accSum + 44'(sv);
			prod = 64'(sv) * 64'(sv);
			sSq = st.accSq + {12'h000, prod};
			next_st.accMin = sMin;
			next_st.accMax = sMax;
			next_st.accSum = sSum;
			next_st.accSq = sSq;
			next_st.scanIdx = st.scanIdx + 12'h001;
			if (st.scanIdx + 12'h001 >= st.n) begin
				next_st.scanning = 1'b0;
				mean = 32'(sSum / $signed({32'h00000000, st.n}));
				sqMean = sSq / {64'h0000000000000000, st.n};
				prod = 64'(mean) * 64'(mean);
				meanSq = {12'h000, prod};
				next_st.pMean = mean;
				next_st.sqVal = (sqMean > meanSq) ? 64'(sqMean - meanSq) : 64'h0000000000000000;
				next_st.sqStart = 1'b1;
				next_st.sqrtWait = 1'b1;
			end
		end else if (!st.sqrtWait && st.dirty) begin
			next_st.dirty = 1'b0;
			if (st.n == 12'h000) begin
				next_st.stMin = 32'sh00000000;
				next_st.stMax = 32'sh00000000;
				next_st.stMean = 32'sh00000000;
				next_st.stSd = 32'h00000000;
			end else begin
				next_st.scanning = 1'b1;
				next_st.scanIdx = 12'h000;
				next_st.accMin = 32'sh7FFFFFFF;
				next_st.accMax = 32'sh80000000;
				next_st.accSum = 44'sh00000000000;
				next_st.accSq = 76'h0000000000000000000;
			end
		end
		if (sqDone) begin
			next_st.sqrtWait = 1'b0;
			next_st.stMin = st.accMin;
			next_st.stMax = st.accMax;
			next_st.stMean = st.pMean;
			next_st.stSd = sqRoot;
		end

		// Register reads answer in the following cycle; reading status clears the refusal flags.
		ctrlWord[`RPB_C_REL] = st.relEn;
		ctrlWord[`RPB_C_FILT] = st.filtEn;
		ctrlWord[`RPB_C_MATH] = st.mathEn;
		ctrlWord[`RPB_C_CALC] = st.bufCalc;
		ctrlWord[`RPB_C_STATCUR] = st.statCur;
		ctrlWord[`RPB_C_AUTOCLR] = st.autoClear;
		ctrlWord[`RPB_C_MODE] = st.mode;
		if (regRd) begin
			unique case (regAddr)
				`RPB_A_CTRL:   next_st.rdata = ctrlWord;
				`RPB_A_RELV:   next_st.rdata = st.relV;
				`RPB_A_RELI:   next_st.rdata = st.relI;
				`RPB_A_FCOUNT: next_st.rdata = {25'h0000000, st.fCount};
				`RPB_A_FWIN:   next_st.rdata = st.fWin;
				`RPB_A_GAIN:   next_st.rdata = st.gain;
				`RPB_A_OFFS:   next_st.rdata = st.offs;
				`RPB_A_BSIZE:  next_st.rdata = {20'h00000, st.bSize};
				`RPB_A_STATUS: begin
					next_st.rdata = 32'h00000000;
					next_st.rdata[`RPB_S_COUNT] = st.n;
					next_st.rdata[`RPB_S_BUSY] = st.scanning | st.sqrtWait | st.dirty;
					next_st.rdata[`RPB_S_REFUSED] = st.refused;
					next_st.refused = 4'h0;
				end
				`RPB_A_STMIN:  next_st.rdata = st.stMin;
				`RPB_A_STMAX:  next_st.rdata = st.stMax;
				`RPB_A_STPP:   next_st.rdata = 32'(st.stMax - st.stMin);
				`RPB_A_STMEAN: next_st.rdata = st.stMean;
				`RPB_A_STSD:   next_st.rdata = st.stSd;
				`RPB_A_RDIDX:  next_st.rdata = {20'h00000, st.rdIdx};
				`RPB_A_RDV:    next_st.rdata = memV[st.rdIdx];
				`RPB_A_RDI:    next_st.rdata = memI[st.rdIdx];
				`RPB_A_RDTS:   next_st.rdata = memTs[st.rdIdx];
				`RPB_A_RDNUM:  next_st.rdata = memNum[st.rdIdx];
				default:       next_st.rdata = 32'h00000000;
			endcase
		end

		// Register writes; out-of-range values leave the old setting and raise a sticky flag.
		if (regWr) begin
			unique case (regAddr)
				`RPB_A_CTRL: begin
					next_st.relEn = regWdata[`RPB_C_REL];
					next_st.filtEn = regWdata[`RPB_C_FILT];
					next_st.mathEn = regWdata[`RPB_C_MATH];
					next_st.bufCalc = regWdata[`RPB_C_CALC];
					next_st.statCur = regWdata[`RPB_C_STATCUR];
					next_st.autoClear = regWdata[`RPB_C_AUTOCLR];
					next_st.mode = (regWdata[`RPB_C_MODE] == 2'b11) ? RPB_FILL_NEVER
						: rpb_fill_type'(regWdata[`RPB_C_MODE]);
					if (regWdata[`RPB_C_STATCUR] != st.statCur) begin
						next_st.dirty = 1'b1;
					end
				end
				`RPB_A_RELV: next_st.relV = regWdata;
				`RPB_A_RELI: next_st.relI = regWdata;
				`RPB_A_FCOUNT: begin
					if (regWdata < 32'(`RPB_FCOUNT_MIN) || regWdata > 32'(`RPB_FCOUNT_MAX)) begin
						next_st.refused[2] = 1'b1;
					end else begin
						next_st.fCount = regWdata[6:0];
						next_st.fN = '0;
						next_st.fPos = '0;
						next_st.fSum = '0;
					end
				end
				`RPB_A_FWIN: next_st.fWin = regWdata;
				`RPB_A_GAIN: begin
					if ($signed(regWdata) > `RPB_GAIN_LIM || $signed(regWdata) < -`RPB_GAIN_LIM) begin
						next_st.refused[0] = 1'b1;
					end else begin
						next_st.gain = regWdata;
					end
				end
				`RPB_A_OFFS: begin
					if ($signed(regWdata) > `RPB_OFFS_LIM || $signed(regWdata) < -`RPB_OFFS_LIM) begin
						next_st.refused[1] = 1'b1;
					end else begin
						next_st.offs = regWdata;
					end
				end
				`RPB_A_BSIZE: begin
					if (regWdata < 32'(`RPB_BSIZE_MIN) || regWdata > 32'(`RPB_BSIZE_MAX)) begin
						next_st.refused[3] = 1'b1;
					end else begin
						next_st.bSize = regWdata[11:0];
						doClear = 1'b1;
					end
				end
				`RPB_A_CMD: begin
					if (regWdata[`RPB_K_ACQ]) begin
						next_st.relV = st.lastV;
						next_st.relI = st.lastI;
					end
					if (regWdata[`RPB_K_CLEAR] || (regWdata[`RPB_K_RUN] && st.autoClear)) begin
						doClear = 1'b1;
					end
				end
				`RPB_A_RDIDX: next_st.rdIdx = regWdata[11:0];
				default: ;
			endcase
		end
		// A clear abandons any rescan in flight, so no scan ever divides by an emptied count.
		if (doClear) begin
			next_st.scanning = 1'b0;
			next_st.n = 12'h000;
			next_st.wp = 12'h000;
			next_st.seq = 32'h00000000;
			next_st.dirty = 1'b1;
		end

		// Reading path: both quantities arrive together and share one strobe.
		if (inValid) begin
			next_st.lastV = inV;
			next_st.lastI = inI;
			for (int ch = 0; ch < 2; ch++) begin
				x = $signed(ch == 0 ? inV : inI);
				if (st.relEn) begin
					x = x - (ch == 0 ? st.relV : st.relI);
				end
				sum = next_st.fSum[ch];
				cnt = next_st.fN[ch];
				avgOld = (cnt == 7'h00) ? 32'sh00000000 : 32'($signed(sum) / $signed({33'h000000000, cnt}));
				diff = 33'(x) - 33'(avgOld);
				if (!st.filtEn) begin
					filt = x;
					next_st.fN[ch] = 7'h00;
					next_st.fPos[ch] = 7'h00;
					next_st.fSum[ch] = 40'h0000000000;
				end else begin
					if (cnt == 7'h00 || (diff < 0 ? -diff : diff) > $signed({1'b0, st.fWin})) begin
						sum = 40'(x);
						cnt = 7'h01;
						histWe[ch] = 1'b1;
						histAddr[ch] = 7'h00;
						next_st.fPos[ch] = 7'h01;
					end else begin
						histWe[ch] = 1'b1;
						histAddr[ch] = next_st.fPos[ch];
						if (cnt < next_st.fCount) begin
							sum = 40'($signed(sum) + 40'(x));
							cnt = cnt + 7'h01;
						end else begin
							sum = 40'($signed(sum) + 40'(x) - 40'($signed(histRd[ch])));
						end
						next_st.fPos[ch] = (next_st.fPos[ch] + 7'h01 >= next_st.fCount) ? 7'h00
							: next_st.fPos[ch] + 7'h01;
					end
					histData[ch] = x;
					next_st.fSum[ch] = sum;
					next_st.fN[ch] = cnt;
					filt = 32'($signed(sum) / $signed({33'h000000000, cnt}));
				end
				prod = 64'(st.gain) * 64'(filt);
				mth = 32'(prod >>> `RPB_GAIN_FRAC) + st.offs;
				if (ch == 0) begin
					next_st.outV = st.mathEn ? mth : filt;
				end else begin
					next_st.outI = st.mathEn ? mth : filt;
				end
				memData[ch] = (st.bufCalc && st.mathEn) ? mth : filt;
			end
			next_st.outValid = 1'b1;
			if (st.mode == RPB_FILL_ALWAYS || (st.mode == RPB_FILL_NEXT && next_st.n < next_st.bSize)) begin
				memWe = 1'b1;
				memAddr = next_st.wp;
				memNumData = next_st.seq + 32'h00000001;
				next_st.seq = next_st.seq + 32'h00000001;
				next_st.wp = (next_st.wp + 12'h001 >= next_st.bSize) ? 12'h000 : next_st.wp + 12'h001;
				next_st.n = (next_st.n < next_st.bSize) ? next_st.n + 12'h001 : next_st.n;
				next_st.dirty = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Registers and memories.
	// ------------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.fCount <= `RPB_RST_FCOUNT;
			st.fWin <= `RPB_RST_FWIN;
			st.gain <= `RPB_RST_GAIN;
			st.bSize <= `RPB_RST_BSIZE;
		end else begin
			st <= next_st;
		end
	end

	// Buffer entries carry no reset; the entry count alone says what is valid.
	always_ff @(posedge clk) begin
		if (memWe) begin
			memV[memAddr] <= memData[0];
			memI[memAddr] <= memData[1];
			memTs[memAddr] <= st.tstamp;
			memNum[memAddr] <= memNumData;
		end
	end

	// Averaging history, one store per quantity.
	for (genvar ch = 0; ch < 2; ch++) begin : g_hist
		logic [31:0] hist [0:`RPB_FILT_DEPTH-1];
		always_ff @(posedge clk) begin
			if (histWe[ch]) begin
				hist[histAddr[ch]] <= histData[ch];
			end
		end
		assign histRd[ch] = hist[st.fPos[ch]];
	end

	assign regRdata = st.rdata;
	assign outValid = st.outValid;
	assign outV = st.outV;
	assign outI = st.outI;

	// ------------------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_rel_hold: assert property (!(regWr && regAddr inside {`RPB_A_RELV, `RPB_A_CMD}) |=> $stable(st.relV))
		else $error("relative offset changed without write or acquire");
	chk_rel_subtract: assert property (inValid && st.relEn && !st.filtEn && !st.mathEn
		|=> outValid && outV == 32'($past(inV) - $past(st.relV)))
		else $error("relative offset not subtracted");
	chk_acquire_copy: assert property (regWr && regAddr == `RPB_A_CMD && regWdata[`RPB_K_ACQ]
		|=> st.relI == $past(st.lastI))
		else $error("acquire did not copy the reading");
	chk_filter_count: assert property (st.fN[0] <= st.fCount && st.fN[1] <= st.fCount)
		else $error("filter history exceeds count");
	chk_bypass_path: assert property (inValid && !st.relEn && !st.filtEn && !st.mathEn
		|=> outValid && outV == $past(inV) && outI == $past(inI))
		else $error("bypass reading altered");
	chk_math_result: assert property (inValid && !st.relEn && !st.filtEn && st.mathEn
		|=> outV == 32'(32'((64'($past(st.gain)) * 64'($signed($past(inV)))) >>> `RPB_GAIN_FRAC) + $past(st.offs))[*1])
		else $error("math result wrong");
	chk_gain_refused: assert property (regWr && regAddr == `RPB_A_GAIN && $signed(regWdata) > `RPB_GAIN_LIM
		|=> $stable(st.gain) && st.refused[0])
		else $error("out-of-range gain accepted");
	chk_fill_never: assert property (st.mode == RPB_FILL_NEVER && !(regWr && regAddr inside {`RPB_A_CMD, `RPB_A_BSIZE})
		|=> $stable(st.n))
		else $error("buffer grew in never mode");
	chk_clear_empty: assert property (regWr && regAddr == `RPB_A_CMD && regWdata[`RPB_K_CLEAR] && !inValid
		|=> st.n == 12'h000 && st.wp == 12'h000 && st.seq == 32'h00000000)
		else $error("clear left entries");
	chk_size_limit: assert property (st.n <= st.bSize && st.bSize >= `RPB_BSIZE_MIN)
		else $error("entry count beyond capacity");
endmodule

// file: logic/rpb_defines.svh
// Register offsets, field positions, reset values and limits of the reading post-processing buffer.
//
// Notes on behaviour
// - With relative offset on, each reading leaves as measured value minus stored offset.
// - The acquire command copies the present reading into the relative offset registers.
// - Relative offsets are software-writable and reset to zero.
// - The filter is a moving average whose newest reading replaces the oldest one.
// - The filter averages between 2 and 100 readings, as programmed.
// - Readings inside the filter window keep entering the averaging store.
// - A reading outside the window drops the history and restarts the average.
// - A filter enable selects averaged or bypassed readings.
// - With math on, every reading becomes gain times reading plus offset.
// - Gain values beyond plus or minus one million are refused.
// - Offset values beyond plus or minus one million are refused.
// - A data-type selector stores either pre-math or post-math readings.
// - Buffer capacity is programmable from 2 to 2500 entries.
// - Accepting a new buffer capacity empties the buffer.
// - Fill mode is wrap-and-overwrite, stop when full, or store nothing.
// - Minimum, maximum, peak-to-peak, mean and standard deviation cover the buffer.
// - Statistics cover either current or voltage, chosen by a selector.
// - With auto-clear on, starting a storage run empties the buffer.
// - The clear command removes every buffer entry.
// - Each entry holds voltage, current, timestamp and sequential reading number.
`ifndef RPB_DEFINES_SVH
`define RPB_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte addresses.
// ----------------------------------------------------------------------------
`define RPB_A_CTRL    8'h00
`define RPB_A_RELV    8'h04
`define RPB_A_RELI    8'h08
`define RPB_A_FCOUNT  8'h0C
`define RPB_A_FWIN    8'h10
`define RPB_A_GAIN    8'h14
`define RPB_A_OFFS    8'h18
`define RPB_A_BSIZE   8'h1C
`define RPB_A_CMD     8'h20
`define RPB_A_STATUS  8'h24
`define RPB_A_STMIN   8'h28
`define RPB_A_STMAX   8'h2C
`define RPB_A_STPP    8'h30
`define RPB_A_STMEAN  8'h34
`define RPB_A_STSD    8'h38
`define RPB_A_RDIDX   8'h3C
`define RPB_A_RDV     8'h40
`define RPB_A_RDI     8'h44
`define RPB_A_RDTS    8'h48
`define RPB_A_RDNUM   8'h4C

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define RPB_C_REL      0
`define RPB_C_FILT     1
`define RPB_C_MATH     2
`define RPB_C_CALC     3
`define RPB_C_STATCUR  4
`define RPB_C_AUTOCLR  5
`define RPB_C_MODE     7:6
`define RPB_K_ACQ      0
`define RPB_K_CLEAR    1
`define RPB_K_RUN      2
`define RPB_S_COUNT    11:0
`define RPB_S_BUSY     12
`define RPB_S_REFUSED  19:16

// ----------------------------------------------------------------------------
// Reset values, limits and depths.
// ----------------------------------------------------------------------------
`define RPB_RST_FCOUNT 7'h0A
`define RPB_RST_FWIN   32'h00000100
`define RPB_RST_GAIN   32'sh00000400
`define RPB_RST_BSIZE  12'h064
`define RPB_FCOUNT_MIN 7'h02
`define RPB_FCOUNT_MAX 7'h64
`define RPB_BSIZE_MIN  12'h002
`define RPB_BSIZE_MAX  12'h9C4
`define RPB_GAIN_LIM   32'sh3D090000
`define RPB_OFFS_LIM   32'sh000F4240
`define RPB_GAIN_FRAC  10
`define RPB_FILT_DEPTH 100
`define RPB_BUF_DEPTH  2500

`endif

// file: logic/rpb_pkg.sv
// Types shared by the reading post-processing buffer modules.
package rpb_pkg;

	// Buffer fill modes.
	typedef enum logic [1:0] {
		RPB_FILL_ALWAYS = 2'b00,
		RPB_FILL_NEXT   = 2'b01,
		RPB_FILL_NEVER  = 2'b10
	} rpb_fill_type;

	// Whole state of the square-root engine.
	typedef struct packed {
		logic        busy;
		logic        done;
		logic [4:0]  bitIdx;
		logic [31:0] root;
		logic [63:0] val;
	} rpb_sqrt_state_type;

	// Whole state of the post-processing chain.
	typedef struct packed {
		logic                relEn, filtEn, mathEn, bufCalc, statCur, autoClear;
		rpb_fill_type        mode;
		logic signed [31:0]  relV, relI, lastV, lastI, gain, offs;
		logic [31:0]         fWin;
		logic [6:0]          fCount;
		logic [1:0][6:0]     fN, fPos;
		logic [1:0][39:0]    fSum;
		logic [11:0]         bSize, n, wp, rdIdx, scanIdx;
		logic [31:0]         seq, tstamp, rdata;
		logic [3:0]          refused;
		logic                outValid;
		logic [31:0]         outV, outI;
		logic                dirty, scanning, sqrtWait, sqStart;
		logic [63:0]         sqVal;
		logic signed [31:0]  accMin, accMax, pMean, stMin, stMax, stMean;
		logic [31:0]         stSd;
		logic signed [43:0]  accSum;
		logic [75:0]         accSq;
	} rpb_state_type;

endpackage

// file: logic/rpb_isqrt.sv
// Bit-serial integer square root used for the standard deviation.
`timescale 1ns/10ps
module rpb_isqrt (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Request.
	input  wire logic        start,
	input  wire logic [63:0] radicand,
	// Answer.
	output logic             done,
	output logic [31:0]      root
);
	import rpb_pkg::*;

	rpb_sqrt_state_type st;
	rpb_sqrt_state_type next_st;

	// One result bit per cycle; slow but tiny, and statistics are not urgent.
	always_comb begin
		logic [31:0] trial;
		logic [63:0] sq;
		trial = st.root | (32'h00000001 << st.bitIdx);
		sq = 64'(trial) * 64'(trial);
		next_st = st;
		next_st.done = 1'b0;
		if (start) begin
			next_st.busy = 1'b1;
			next_st.bitIdx = 5'h1F;
			next_st.root = 32'h00000000;
			next_st.val = radicand;
		end else if (st.busy) begin
			if (sq <= st.val) begin
				next_st.root = trial;
			end
			if (st.bitIdx == 5'h00) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end else begin
				next_st.bitIdx = st.bitIdx - 5'h01;
			end
		end
	end

	// State register.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign done = st.done;
	assign root = st.root;

	chk_sqrt_latency: assert property (@(posedge clk) disable iff (!rst_n) start |=> ##32 done)
		else $error("square root did not finish in 33 cycles");
endmodule

// file: test/rpb_front_end.sv
// Measurement front end model that feeds paired voltage and current readings.
`timescale 1ns/10ps
module rpb_front_end (
	// Clock.
	input  wire logic   clk,
	// Readings.
	output logic        inValid,
	output logic [31:0] inV,
	output logic [31:0] inI
);
	// Idle until the first reading is sent.
	initial begin
		inValid = 1'b0;
		inV = 32'h0;
		inI = 32'h0;
	end

	// One strobe carries both quantities of one instant; between strobes the data lines show the
	// inverse of the last value, so a design that samples them late picks up garbage.
	task automatic send(input logic [31:0] v, input logic [31:0] i);
		@(posedge clk);
		inValid <= 1'b1;
		inV <= v;
		inI <= i;
		@(posedge clk);
		inValid <= 1'b0;
		inV <= ~v;
		inI <= ~i;
	endtask
endmodule

// file: test/testbench.sv
// Self-checking testbench for the reading post-processing buffer.
`timescale 1ns/10ps
`include "rpb_defines.svh"
module testbench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        inValid;
	logic [31:0] inV, inI;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [31:0] regRdata, outV, outI, rv;
	logic        outValid;
	int          mismatches = 0;
	int          checks_done = 0;

	// Free-running clock of 10 ns.
	always #5 clk = ~clk;

	rpb_front_end i_rpb_front_end (.clk(clk), .inValid(inValid), .inV(inV), .inI(inI));
	rpb_top i_rpb_top (.clk(clk), .rst_n(rst_n), .inValid(inValid), .inV(inV), .inI(inI),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.outValid(outValid), .outV(outV), .outI(outI));

	// ------------------------------------------------------------------------
	// Shared tasks.
	// ------------------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	// Read data appear in the cycle after the strobe and hold until the next read; they are sampled there.
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 rv = regRdata;
		chk(rv, e);
	endtask
	// The processed reading is registered at the edge that ends the strobe.
	task automatic put(input logic [31:0] v, input logic [31:0] i, input logic [31:0] e);
		i_rpb_front_end.send(v, i);
		#1 chk(outV, e);
		chk({31'h0, outValid}, 32'h1);
	endtask
	// Polls the busy flag of the statistics under a bound; returns the entry count in rv.
	task automatic settle();
		int k;
		repeat (4) @(posedge clk);
		for (k = 0; k < 300; k++) begin
			@(posedge clk);
			regRd <= 1'b1;
			regAddr <= `RPB_A_STATUS;
			@(posedge clk);
			regRd <= 1'b0;
			#1 rv = regRdata;
			if (rv[`RPB_S_BUSY] === 1'b0) break;
		end
		if (k == 300) begin
			mismatches++;
			give_verdict();
		end
	endtask

	// ------------------------------------------------------------------------
	// Scenarios.
	// ------------------------------------------------------------------------
	task automatic t_rel_math();
		rd(`RPB_A_RELV, 32'h0);
		rd(8'hF0, 32'h0);
		wr(`RPB_A_RELV, 32'h64);
		wr(`RPB_A_CTRL, 32'h1);
		put(32'h96, 32'h9, 32'h32);
		chk(outI, 32'h9);
		wr(`RPB_A_CMD, 32'h1);
		rd(`RPB_A_RELV, 32'h96);
		rd(`RPB_A_RELI, 32'h9);
		wr(`RPB_A_CTRL, 32'h5);
		wr(`RPB_A_GAIN, 32'h800);
		wr(`RPB_A_OFFS, 32'h3);
		put(32'hA0, 32'h9, 32'h17);
		settle();
		wr(`RPB_A_GAIN, 32'h3D090001);
		rd(`RPB_A_GAIN, 32'h800);
		wr(`RPB_A_OFFS, 32'hFFF0BDBF);
		rd(`RPB_A_OFFS, 32'h3);
		rd(`RPB_A_STATUS, 32'h30002);
	endtask
	task automatic t_filt();
		rd(`RPB_A_FCOUNT, 32'hA);
		wr(`RPB_A_CTRL, 32'h2);
		wr(`RPB_A_FCOUNT, 32'h2);
		wr(`RPB_A_FCOUNT, 32'h1);
		rd(`RPB_A_FCOUNT, 32'h2);
		put(32'hA, 32'h0, 32'hA);
		put(32'h14, 32'h0, 32'hF);
		put(32'h1E, 32'h0, 32'h19);
		put(32'h3E8, 32'h0, 32'h3E8);
		wr(`RPB_A_CTRL, 32'h0);
		put(32'h7, 32'h0, 32'h7);
	endtask
	task automatic t_buf();
		wr(`RPB_A_CTRL, 32'h40);
		wr(`RPB_A_BSIZE, 32'h2);
		put(32'h4, 32'h1, 32'h4);
		put(32'h8, 32'h3, 32'h8);
		put(32'h64, 32'h5, 32'h64);
		settle();
		chk({20'h0, rv[`RPB_S_COUNT]}, 32'h2);
		rd(`RPB_A_STMIN, 32'h4);
		rd(`RPB_A_STMAX, 32'h8);
		rd(`RPB_A_STPP, 32'h4);
		rd(`RPB_A_STMEAN, 32'h6);
		rd(`RPB_A_STSD, 32'h2);
		wr(`RPB_A_RDIDX, 32'h0);
		rd(`RPB_A_RDV, 32'h4);
		rd(`RPB_A_RDI, 32'h1);
		rd(`RPB_A_RDNUM, 32'h1);
		wr(`RPB_A_CTRL, 32'h50);
		settle();
		rd(`RPB_A_STMAX, 32'h3);
		wr(`RPB_A_CTRL, 32'h60);
		wr(`RPB_A_CMD, 32'h4);
		settle();
		chk({20'h0, rv[`RPB_S_COUNT]}, 32'h0);
		rd(`RPB_A_STMAX, 32'h0);
		wr(`RPB_A_CTRL, 32'h4C);
		put(32'h5, 32'h0, 32'hD);
		rd(`RPB_A_RDV, 32'hD);
		wr(`RPB_A_CMD, 32'h2);
		settle();
		chk({20'h0, rv[`RPB_S_COUNT]}, 32'h0);
		wr(`RPB_A_CTRL, 32'h80);
		put(32'h9, 32'h0, 32'h9);
		rd(`RPB_A_STATUS, 32'h0);
	endtask

	// Reset for 8 cycles, then the scenarios in turn.
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_rel_math();
		t_filt();
		t_buf();
		give_verdict();
	end
endmodule
